// >>> hdl/psram_cfg.svh
/*
 Constants of the pipelined synchronous memory port: widths, burst
 counter steps, byte masks and buffer depth.
 Assumes inclusion by bare name from every module file of the port.
*/
`ifndef PSRAM_CFG_SVH
`define PSRAM_CFG_SVH
`define PSRAM_ADDR_W 18
`define PSRAM_DATA_W 32
`define PSRAM_LANES 4
`define PSRAM_LANE_W 8
`define PSRAM_FIFO_DEPTH 16
`define PSRAM_LOW_BITS 2
`define PSRAM_MASK_ALL 4'hf
`define PSRAM_MASK_NONE 4'h0
`define PSRAM_BURST_FIRST 2'h0
`define PSRAM_BURST_STEP 2'h1
`endif

// >>> hdl/psram_pkg.sv
/*
 Types shared by the memory port: the kind of access issued on a
 clock edge.
 Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package psram_pkg;
   typedef enum logic [1:0] {
      PSRAM_OP_IDLE,
      PSRAM_OP_READ,
      PSRAM_OP_WRITE
   } psram_op_type;
endpackage
`default_nettype wire

// >>> hdl/psram_fifo.sv
/*
 Synchronous FIFO with valid and ready on both sides.
 Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "psram_cfg.svh"
module psram_fifo #(
   parameter int WIDTH = 54,
   parameter int DEPTH = `PSRAM_FIFO_DEPTH
) (
   input wire logic clk_sys, // System clock
   input wire logic reset, // Synchronous reset
   input wire logic in_valid, // Entry offered
   output logic in_ready, // Room for an entry
   input wire logic [WIDTH-1:0] in_data, // Entry in
   output logic out_valid, // Entry available
   input wire logic out_ready, // Drain accepts
   output logic [WIDTH-1:0] out_data // Oldest entry
);
   import psram_pkg::*;
   localparam int PW = $clog2(DEPTH);
   typedef struct packed {
      logic [PW-1:0] wp;
      logic [PW-1:0] rp;
      logic [PW:0] cnt;
   } psram_fifo_state_type;
   psram_fifo_state_type st;
   psram_fifo_state_type next_st;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push;
   logic pop;

   assign in_ready = (st.cnt != (PW+1)'(DEPTH));
   assign out_valid = (st.cnt != '0);
   assign out_data = mem[st.rp];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      next_st = st;
      if (push) begin
         next_st.wp = st.wp + PW'(1);
      end
      if (pop) begin
         next_st.rp = st.rp + PW'(1);
      end
      next_st.cnt = st.cnt + (PW+1)'(push) - (PW+1)'(pop);
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem[st.wp] <= in_data;
      end
   end
endmodule
`default_nettype wire

// >>> hdl/psram_array.sv
/*
 Storage array with one byte-masked write port and one read port.
 Assumes write requests synchronous to the clock; read is immediate.
*/
`timescale 1ns/1ps
`default_nettype none
`include "psram_cfg.svh"
module psram_array #(
   parameter int ADDR_W = `PSRAM_ADDR_W,
   parameter int LANES = `PSRAM_LANES
) (
   input wire logic clk_sys, // System clock
   input wire logic wr_en, // Write this cycle
   input wire logic [ADDR_W-1:0] wr_addr, // Write location
   input wire logic [LANES-1:0] wr_be, // Lane write mask
   input wire logic [LANES*8-1:0] wr_data, // Write word
   input wire logic [ADDR_W-1:0] rd_addr, // Read location
   output logic [LANES*8-1:0] rd_data // Read word
);
   import psram_pkg::*;

   // One store per lane, so each lane process owns its own storage
   for (genvar i = 0; i < LANES; i++) begin : g_lane
      logic [7:0] lane_mem [2**ADDR_W];

      assign rd_data[i*8 +: 8] = lane_mem[rd_addr];

      always_ff @(posedge clk_sys) begin
         if (wr_en && wr_be[i]) begin
            lane_mem[wr_addr] <= wr_data[i*8 +: 8];
         end
      end
   end
endmodule
`default_nettype wire

// >>> hdl/psram_port.sv
/*
 Pipelined synchronous memory port with common data bus, two address
 strobes, a two-bit wraparound burst counter and byte writes.
 Assumes all pins but sleep and output enable are synchronous to clk_sys; the data pin
 wire is resolved outside from dq_out and dq_oe.
*/
// Notes on behaviour
// - Inputs but output enable, and read data, pass rising-edge registers
// - Third select active low, combined with others
// - Output enable low drives pins, high floats
// - First read cycle after deselect stays floated
// - Burst step low advances the burst address
// - Processor strobe captures address, loads counter
// - Controller strobe captures address, loads counter
// - Both strobes low: processor strobe wins
// - Processor strobe ignored while first select high
// - Sleep high enters retentive low-power state
// - Input data captured on rising edge
// - Read data appears one cycle after address
// - Order strap low linear, high interleaved
// - Two-bit wraparound burst counter supplies addresses
// - Byte lanes written where selected with enable
// - Global write writes all four lanes
// - Writes are self-timed from clocked controls
// - Interleaved order: start XOR count
// - Linear order: low bits increment, wrap
// - Processor-strobe write completes on next edge
// - Write cycle forces data drivers off
`timescale 1ns/1ps
`default_nettype none
`include "psram_cfg.svh"
module psram_port #(
   parameter int ADDR_W = `PSRAM_ADDR_W,
   parameter int DATA_W = `PSRAM_DATA_W,
   parameter int LANES = `PSRAM_LANES,
   parameter int FIFO_DEPTH = `PSRAM_FIFO_DEPTH
) (
   input wire logic clk_sys, // System clock
   input wire logic reset, // Synchronous reset, high
   input wire logic [ADDR_W-1:0] addr, // Word address
   input wire logic chip_select_first_n, // Select one, low
   input wire logic chip_select_second, // Select two, high
   input wire logic chip_select_third_n, // Select three, low
   input wire logic proc_addr_strobe_n, // Processor strobe, low
   input wire logic ctrl_addr_strobe_n, // Controller strobe, low
   input wire logic burst_step_n, // Burst advance, low
   input wire logic global_write_n, // All-lane write, low
   input wire logic byte_write_enable_n, // Lane write enable, low
   input wire logic [LANES-1:0] byte_lane_sel_n, // Lane selects, low
   input wire logic output_enable_n, // Output enable, low
   input wire logic sleep_request, // Sleep, high
   input wire logic burst_order_interleave, // Strap, high interleaved
   input wire logic [DATA_W-1:0] dq_in, // Data pin input
   output logic [DATA_W-1:0] dq_out, // Data pin output
   output logic dq_oe, // Data pin drive enable
   output logic write_ready, // Write buffer has room
   output logic sleep_active // Sleep state reached
);
   import psram_pkg::*;
   localparam int ENTRY_W = ADDR_W + LANES + DATA_W;
   localparam int LB = `PSRAM_LOW_BITS;

   typedef struct packed {
      logic sleep_meta;
      logic sleeping;
      logic mode;
      logic selected;
      logic active;
      logic mask;
      logic proc_pend;
      psram_op_type op;
      logic [ADDR_W-1:0] base;
      logic [LB-1:0] start;
      logic [LB-1:0] cnt;
      logic [ADDR_W-1:0] cur_addr;
      logic [DATA_W-1:0] dq_out;
      logic drive;
      logic write_ready;
   } psram_port_state_type;

   psram_port_state_type st;
   psram_port_state_type next_st;

   logic [LANES-1:0] wmask;
   logic proc_go;
   logic ctrl_go;
   logic sel;
   logic desel_edge;
   logic step_go;
   logic wr_go;
   logic [ADDR_W-1:0] wr_addr;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [ENTRY_W-1:0] fifo_out_data;
   logic [DATA_W-1:0] arr_rdata;

   // Low address bits for a burst position
   function automatic logic [LB-1:0] burst_low(
      input logic interleave,
      input logic [LB-1:0] start,
      input logic [LB-1:0] cnt
   );
      burst_low = interleave ? (start ^ cnt) : (start + cnt);
   endfunction

   always_comb begin
      next_st = st;
      wr_addr = st.cur_addr;
      wr_go = 1'b0;
      step_go = 1'b0;
      // Global write overrides lane selects
      if (!global_write_n) begin
         wmask = `PSRAM_MASK_ALL;
      end else if (!byte_write_enable_n) begin
         wmask = ~byte_lane_sel_n;
      end else begin
         wmask = `PSRAM_MASK_NONE;
      end
      proc_go = !proc_addr_strobe_n && !chip_select_first_n;
      ctrl_go = !ctrl_addr_strobe_n && !proc_go;
      sel = !chip_select_first_n && chip_select_second
         && !chip_select_third_n;
      desel_edge = (proc_go || ctrl_go) && !sel;
      next_st.sleep_meta = sleep_request;
      next_st.sleeping = st.sleep_meta;
      next_st.write_ready = fifo_in_ready;
      next_st.proc_pend = 1'b0;
      next_st.op = PSRAM_OP_IDLE;
      if (st.op == PSRAM_OP_READ) begin
         next_st.dq_out = arr_rdata;
      end
      if (st.sleeping) begin
         // Accesses are dropped; stored data is kept
         next_st.selected = 1'b0;
         next_st.active = 1'b0;
      end else if (proc_go || ctrl_go) begin
         if (sel) begin
            next_st.base = addr;
            next_st.start = addr[LB-1:0];
            next_st.cnt = `PSRAM_BURST_FIRST;
            next_st.cur_addr = addr;
            next_st.mask = !st.selected;
            next_st.selected = 1'b1;
            next_st.active = 1'b1;
            if (proc_go) begin
               // Write controls wait for the next edge
               next_st.op = PSRAM_OP_READ;
               next_st.proc_pend = 1'b1;
            end else if (wmask != `PSRAM_MASK_NONE) begin
               wr_go = 1'b1;
               wr_addr = addr;
               next_st.op = PSRAM_OP_WRITE;
            end else begin
               next_st.op = PSRAM_OP_READ;
            end
         end else begin
            next_st.selected = 1'b0;
            next_st.active = 1'b0;
         end
      end else if (st.active) begin
         // Step ignored on the edge completing a processor write
         step_go = !burst_step_n && !st.proc_pend;
         if (step_go) begin
            next_st.cnt = st.cnt + `PSRAM_BURST_STEP;
         end
         next_st.cur_addr = {st.base[ADDR_W-1:LB],
            burst_low(st.mode, st.start, next_st.cnt)};
         next_st.mask = 1'b0;
         if (wmask != `PSRAM_MASK_NONE) begin
            wr_go = 1'b1;
            wr_addr = next_st.cur_addr;
            next_st.op = PSRAM_OP_WRITE;
         end else begin
            next_st.op = PSRAM_OP_READ;
         end
      end
      next_st.drive = (st.op == PSRAM_OP_READ) && !st.mask
         && !wr_go && !desel_edge && !st.sleeping;
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         st <= '0;
         // Strap caught while reset is held, then kept
         st.mode <= burst_order_interleave;
      end else begin
         st <= next_st;
      end
   end

   // Asynchronous enable gates the registered drive request
   assign dq_oe = st.drive && !output_enable_n;
   assign dq_out = st.dq_out;
   assign write_ready = st.write_ready;
   assign sleep_active = st.sleeping;

   // Write data taken from the pins at the edge of the write
   psram_fifo #(
      .WIDTH(ENTRY_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_sys(clk_sys),
      .reset(reset),
      .in_valid(wr_go),
      .in_ready(fifo_in_ready),
      .in_data({wr_addr, wmask, dq_in}),
      .out_valid(fifo_out_valid),
      .out_ready(!st.sleeping),
      .out_data(fifo_out_data)
   );

   psram_array #(
      .ADDR_W(ADDR_W),
      .LANES(LANES)
   ) u_array (
      .clk_sys(clk_sys),
      .wr_en(fifo_out_valid && !st.sleeping),
      .wr_addr(fifo_out_data[ENTRY_W-1 -: ADDR_W]),
      .wr_be(fifo_out_data[DATA_W +: LANES]),
      .wr_data(fifo_out_data[DATA_W-1:0]),
      .rd_addr(st.cur_addr),
      .rd_data(arr_rdata)
   );

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);

   write_tristate_a: assert property (
      wr_go |=> !st.drive)
      else $error("Data driven during a write cycle");

   first_read_mask_a: assert property (
      (proc_go || ctrl_go) && sel && !st.selected && !st.sleeping
      && wmask == `PSRAM_MASK_NONE |-> ##2 !st.drive)
      else $error("First read after deselect was driven");

   read_latency_a: assert property (
      st.op == PSRAM_OP_READ |=> st.dq_out == $past(arr_rdata))
      else $error("Read data not one cycle after address");

   strobe_priority_a: assert property (
      proc_go && !ctrl_addr_strobe_n && sel && !st.sleeping
      && wmask != `PSRAM_MASK_NONE |-> !wr_go
      ##1 st.op == PSRAM_OP_READ && st.proc_pend)
      else $error("Controller strobe acted beside processor strobe");

   proc_ignore_a: assert property (
      chip_select_first_n && ctrl_addr_strobe_n
      |=> st.base == $past(st.base))
      else $error("Processor strobe taken with first select high");

   addr_capture_a: assert property (
      (proc_go || ctrl_go) && sel && !st.sleeping
      |=> st.base == $past(addr) && st.cnt == `PSRAM_BURST_FIRST
      && st.start == $past(addr[LB-1:0]))
      else $error("Strobe did not load address and counter");

   linear_step_a: assert property (
      st.active && !proc_go && !ctrl_go && !st.sleeping && step_go
      && !st.mode |=> st.cur_addr[LB-1:0]
      == $past(st.cur_addr[LB-1:0]) + `PSRAM_BURST_STEP)
      else $error("Linear burst did not step by one");

   interleave_step_a: assert property (
      st.active && !proc_go && !ctrl_go && !st.sleeping && step_go
      && st.mode |=> st.cur_addr[LB-1:0]
      == (st.start ^ ($past(st.cnt) + `PSRAM_BURST_STEP)))
      else $error("Interleaved burst address wrong");

   upper_hold_a: assert property (
      st.active && !proc_go && !ctrl_go && !st.sleeping
      |=> st.cur_addr[ADDR_W-1:LB] == $past(st.base[ADDR_W-1:LB]))
      else $error("Burst changed upper address bits");

   lane_write_a: assert property (
      wr_go && global_write_n |-> wmask == ~byte_lane_sel_n
      && !byte_write_enable_n)
      else $error("Byte write lanes wrong");

   global_write_a: assert property (
      !global_write_n && !ctrl_go && !proc_go && st.active
      && !st.sleeping |-> wr_go && wmask == `PSRAM_MASK_ALL)
      else $error("Global write did not write all lanes");

   proc_write_a: assert property (
      proc_go && sel && !st.sleeping && ctrl_addr_strobe_n
      |-> !wr_go ##1 (wmask != `PSRAM_MASK_NONE
      && !proc_go && !ctrl_go && !st.sleeping) |-> wr_go
      && wr_addr == $past(addr))
      else $error("Processor write not done on second edge");

   sleep_enter_a: assert property (
      sleep_request [*3] |-> st.sleeping ##1 !st.drive)
      else $error("Sleep not entered within two cycles");

   burst_read_c: cover property (
      proc_go && sel ##1 !burst_step_n [*3] ##1 st.drive);
   ctrl_write_c: cover property (
      ctrl_go && sel && wmask != `PSRAM_MASK_NONE);
   proc_write_c: cover property (
      proc_go && sel ##1 wr_go);
   fifo_full_c: cover property (
      st.sleeping && !fifo_in_ready);
endmodule
`default_nettype wire

// >>> tb/psram_host.sv
/*
 Bus master model for the memory port: drives the pin controls one
 cycle at a time and resolves the shared data wire.
 Assumes callers enter cyc 1 ns after a rising edge of clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module psram_host (
   input wire logic clk_sys, // System clock
   input wire logic [31:0] dq_out, // Port read data
   input wire logic dq_oe, // Port drive enable
   output logic [5:0] addr, // Word address
   output logic chip_select_first_n, // Select one
   output logic chip_select_second, // Select two
   output logic chip_select_third_n, // Select three
   output logic proc_addr_strobe_n, // Processor strobe
   output logic ctrl_addr_strobe_n, // Controller strobe
   output logic burst_step_n, // Burst advance
   output logic global_write_n, // All-lane write
   output logic byte_write_enable_n, // Lane write enable
   output logic [3:0] byte_lane_sel_n, // Lane selects
   output logic [31:0] dq_in // Resolved data wire
);
   logic drv;
   logic [31:0] wdat;

   // Released wire shows the inverse of the port's word
   assign dq_in = drv ? wdat : (dq_oe ? dq_out : ~dq_out);

   // One bus cycle; ctl packs selects, strobes, step and write controls
   task automatic cyc(input logic [7:0] ctl, input logic [5:0] a,
                      input logic [31:0] d, input logic [3:0] lanes_n);
      {chip_select_first_n, chip_select_second, chip_select_third_n,
       proc_addr_strobe_n, ctrl_addr_strobe_n, burst_step_n,
       global_write_n, byte_write_enable_n} = ctl;
      addr = a;
      wdat = d;
      byte_lane_sel_n = lanes_n;
      drv = !ctl[1] || !ctl[0];
      @(posedge clk_sys);
      #1;
   endtask

   initial begin
      {chip_select_first_n, chip_select_second, chip_select_third_n,
       proc_addr_strobe_n, ctrl_addr_strobe_n, burst_step_n,
       global_write_n, byte_write_enable_n} = 8'h5f;
      addr = 6'h00;
      wdat = 32'h00000000;
      byte_lane_sel_n = 4'hf;
      drv = 1'b0;
   end
endmodule
`default_nettype wire

// >>> tb/test_psram_port.sv
/*
 Self-checking bench of the memory port: global and byte writes,
 strobe priority, first-cycle mask, bursts in both orders, sleep.
 Assumes psram_host as bus master; address width cut to 6 bits.
*/
`timescale 1ns/1ps
`default_nettype none
module test_psram_port;
   localparam logic [7:0] IDLE = 8'h5f;
   localparam logic [7:0] C_RD = 8'h57;
   localparam logic [7:0] C_WR = 8'h55;
   localparam logic [7:0] P_WR = 8'h4e;
   localparam logic [7:0] STEP = 8'h5b;
   localparam logic [7:0] DESEL = 8'h17;
   localparam logic [7:0] B_WR = 8'h5e;
   localparam logic [7:0] G_STEP = 8'h59;
   localparam logic [7:0] GWR = 8'h5d;
   localparam logic [7:0] P_H = 8'hcf;
   localparam logic [7:0] BOTH = 8'h45;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic sleep_request = 1'b0;
   logic output_enable_n = 1'b0;
   logic burst_order_interleave = 1'b1;
   logic [5:0] addr;
   logic cs1_n, cs2, cs3_n, ps_n, cc_n, step_n, all_wr_n, lane_wen_n;
   logic [3:0] lanes_n;
   logic [31:0] dq_in, dq_out;
   logic dq_oe, write_ready, sleep_active;
   logic [31:0] exp_mem [64];
   int n_errors = 0;
   int n_checks = 0;
   int cycles = 0;

   always #2.5 clk_sys = ~clk_sys;

   psram_port #(.ADDR_W(6)) u_dut (.clk_sys(clk_sys), .reset(reset),
      .addr(addr), .chip_select_first_n(cs1_n),
      .chip_select_second(cs2), .chip_select_third_n(cs3_n),
      .proc_addr_strobe_n(ps_n), .ctrl_addr_strobe_n(cc_n),
      .burst_step_n(step_n), .global_write_n(all_wr_n),
      .byte_write_enable_n(lane_wen_n), .byte_lane_sel_n(lanes_n),
      .output_enable_n(output_enable_n), .sleep_request(sleep_request),
      .burst_order_interleave(burst_order_interleave), .dq_in(dq_in),
      .dq_out(dq_out), .dq_oe(dq_oe), .write_ready(write_ready),
      .sleep_active(sleep_active));

   psram_host u_host (.clk_sys(clk_sys), .dq_out(dq_out), .dq_oe(dq_oe),
      .addr(addr), .chip_select_first_n(cs1_n),
      .chip_select_second(cs2), .chip_select_third_n(cs3_n),
      .proc_addr_strobe_n(ps_n), .ctrl_addr_strobe_n(cc_n),
      .burst_step_n(step_n), .global_write_n(all_wr_n),
      .byte_write_enable_n(lane_wen_n), .byte_lane_sel_n(lanes_n),
      .dq_in(dq_in));

   task automatic final_report();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk_word(string what, logic [31:0] e, logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic chk_bit(string what, logic e, logic g);
      n_checks++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value %s expected %b seen %b", what, e, g);
      end
   endtask

   // Hang guard
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles > 20000) begin
         n_errors++;
         final_report();
      end
   end

   function automatic logic [31:0] wd(int a);
      return 32'hc0de0000 + 32'(a);
   endfunction

   task automatic do_reset(input logic ilv);
      reset = 1'b1;
      burst_order_interleave = ilv;
      repeat (4) @(posedge clk_sys);
      #1;
      reset = 1'b0;
      u_host.cyc(IDLE, 6'h00, 32'h0, 4'hf);
      chk_word("dq_out after reset", 32'h0, dq_out);
      chk_bit("dq_oe after reset", 1'b0, dq_oe);
      chk_bit("sleep after reset", 1'b0, sleep_active);
      u_host.cyc(IDLE, 6'h00, 32'h0, 4'hf);
      chk_bit("write_ready", 1'b1, write_ready);
   endtask

   task automatic wr_ctrl(int a, logic [31:0] d);
      u_host.cyc(C_WR, 6'(a), d, 4'hf);
      exp_mem[a] = d;
   endtask

   // Read from a, n samples, stepping or repeating the address
   task automatic rd_seq(int a, int n, bit step, bit fresh, bit ilv);
      logic [5:0] la;
      logic [1:0] k;
      logic [5:0] ea;
      la = 6'(a);
      u_host.cyc(IDLE, la, 32'h0, 4'hf);
      u_host.cyc(C_RD, la, 32'h0, 4'hf);
      for (int i = 0; i < n; i++) begin
         u_host.cyc(step ? STEP : IDLE, la, 32'h0, 4'hf);
         k = step ? 2'(i) : 2'h0;
         ea = {la[5:2], ilv ? la[1:0] ^ k : la[1:0] + k};
         chk_word("read data", exp_mem[ea], dq_out);
         chk_bit("read drive", !(fresh && i == 0), dq_oe);
      end
   endtask

   task automatic t_oe();
      output_enable_n = 1'b1;
      u_host.cyc(IDLE, 6'h09, 32'h0, 4'hf);
      chk_bit("drive with oe high", 1'b0, dq_oe);
      output_enable_n = 1'b0;
      u_host.cyc(IDLE, 6'h09, 32'h0, 4'hf);
      chk_bit("drive with oe low", 1'b1, dq_oe);
   endtask

   task automatic t_byte();
      logic [31:0] m;
      m = exp_mem[8];
      u_host.cyc(P_WR, 6'h08, 32'hffffffff, 4'h0);
      u_host.cyc(B_WR, 6'h08, 32'h11223344, 4'ha);
      chk_bit("drive during write", 1'b0, dq_oe);
      exp_mem[8] = {m[31:24], 8'h22, m[15:8], 8'h44};
      // Stepped global write in the burst lands on the next word
      u_host.cyc(G_STEP, 6'h08, 32'h600d0009, 4'hf);
      exp_mem[9] = 32'h600d0009;
      u_host.cyc(DESEL, 6'h08, 32'h0, 4'hf);
      rd_seq(8, 1, 1'b0, 1'b1, 1'b1);
   endtask

   task automatic t_strobes();
      u_host.cyc(DESEL, 6'h0a, 32'h0, 4'hf);
      u_host.cyc(GWR, 6'h0a, 32'hbad0bad0, 4'hf);
      u_host.cyc(BOTH, 6'h0a, 32'hbad1bad1, 4'hf);
      u_host.cyc(P_H, 6'h0a, 32'h0, 4'hf);
      u_host.cyc(IDLE, 6'h0a, 32'h0, 4'hf);
      chk_word("strobe priority", wd(10), dq_out);
      chk_bit("ignored strobe", 1'b1, dq_oe);
      rd_seq(10, 1, 1'b0, 1'b0, 1'b1);
   endtask

   task automatic t_sleep();
      u_host.cyc(DESEL, 6'h09, 32'h0, 4'hf);
      sleep_request = 1'b1;
      u_host.cyc(IDLE, 6'h09, 32'h0, 4'hf);
      chk_bit("sleep entry 1", 1'b0, sleep_active);
      u_host.cyc(IDLE, 6'h09, 32'h0, 4'hf);
      chk_bit("sleep entry 2", 1'b1, sleep_active);
      u_host.cyc(C_WR, 6'h09, 32'hbad2bad2, 4'hf);
      sleep_request = 1'b0;
      u_host.cyc(IDLE, 6'h09, 32'h0, 4'hf);
      u_host.cyc(IDLE, 6'h09, 32'h0, 4'hf);
      chk_bit("sleep exit", 1'b0, sleep_active);
      u_host.cyc(DESEL, 6'h09, 32'h0, 4'hf);
      rd_seq(9, 1, 1'b0, 1'b1, 1'b1);
   endtask

   initial begin
      do_reset(1'b1);
      for (int a = 8; a < 16; a++) wr_ctrl(a, wd(a));
      u_host.cyc(DESEL, 6'h09, 32'h0, 4'hf);
      rd_seq(9, 2, 1'b0, 1'b1, 1'b1);
      t_oe();
      for (int s = 0; s < 4; s++) rd_seq(12 + s, 4, 1'b1, 1'b0, 1'b1);
      t_byte();
      t_strobes();
      t_sleep();
      do_reset(1'b0);
      for (int a = 16; a < 20; a++) wr_ctrl(a, wd(a));
      for (int s = 0; s < 4; s++) rd_seq(16 + s, 4, 1'b1, 1'b0, 1'b0);
      final_report();
   end
endmodule
`default_nettype wire
